// ===== caje_core.sv
// Execution datapath of the 8-bit core: byte and word arithmetic, logic,
// multiplies, jumps and single-bit I/O read-modify-write.
// Assumes the decoder presents operand values and flags with each start
// strobe and commits the result fields when the done pulse is seen.
`timescale 1ns/1ns
module caje_core
  import caje_pkg::*;
(
  input  wire logic                I_CLK,    // Core clock, 50 MHz
  input  wire logic                I_RST,    // Synchronous reset, active high
  input  wire logic                I_START,  // Start strobe, taken while idle
  input  wire caje_pkg::caje_req_s I_REQ,    // Instruction and operands
  output logic                     O_BUSY,   // Instruction in progress
  output logic                     O_DONE,   // One-cycle completion pulse
  output caje_pkg::caje_res_s      O_RES     // Result, held until the next start is taken
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    caje_state_e      state;  // Controller state
    logic [CNT_W-1:0] cnt;    // Cycles left including the current one
    logic             done;   // Completion pulse
    caje_res_s        res;    // Latched outcome
  } caje_regs_s;

  caje_regs_s  regs_r;    // Registered state
  caje_regs_s  regs_nxt;  // Next state
  caje_res_s   calc;      // Outcome of the offered instruction
  logic [CNT_W-1:0] cyc;  // Its cycle count

  // Multiplier hookup
  logic          mul_a_s;  // Left operand signed
  logic          mul_b_s;  // Right operand signed
  logic          mul_frac; // Fractional form
  logic [WW-1:0] mul_prod; // Stored product
  logic          mul_c;    // Carry out

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Byte add or subtract with carry-in; borrow reads as carry on subtract
  function automatic caje_sum_s arith8(input logic [DW-1:0] a,
                                       input logic [DW-1:0] b,
                                       input logic          cin,
                                       input logic          sub);
    caje_sum_s  o;
    logic [DW:0] full;
    logic [4:0]  nib;
    o = '0;
    if (sub) begin
      full = {1'h0, a} - {1'h0, b} - {8'h00, cin};
      nib  = {1'h0, a[3:0]} - {1'h0, b[3:0]} - {4'h0, cin};
      o.v  = (a[DW-1] & ~b[DW-1] & ~full[DW-1]) | (~a[DW-1] & b[DW-1] & full[DW-1]);
    end else begin
      full = {1'h0, a} + {1'h0, b} + {8'h00, cin};
      nib  = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, cin};
      o.v  = (a[DW-1] & b[DW-1] & ~full[DW-1]) | (~a[DW-1] & ~b[DW-1] & full[DW-1]);
    end
    o.res = {8'h00, full[DW-1:0]};
    o.c   = full[DW];
    o.h   = nib[4];
    return o;
  endfunction

  // Word add or subtract of an unsigned constant; no half carry on pairs
  function automatic caje_sum_s arith16(input logic [WW-1:0] a,
                                        input logic [DW-1:0] k,
                                        input logic          sub);
    caje_sum_s   o;
    logic [WW:0] full;
    o = '0;
    if (sub) begin
      full = {1'h0, a} - {9'h000, k};
      o.v  = a[WW-1] & ~full[WW-1];
    end else begin
      full = {1'h0, a} + {9'h000, k};
      o.v  = ~a[WW-1] & full[WW-1];
    end
    o.res = full[WW-1:0];
    o.c   = full[WW];
    return o;
  endfunction

  // Logic result flags: overflow cleared, sign equals negative
  function automatic caje_sreg_s logic_flags(input caje_sreg_s old, input logic [DW-1:0] r);
    caje_sreg_s f;
    f   = old;
    f.z = (r == 8'h00);
    f.n = r[DW-1];
    f.v = 1'h0;
    f.s = f.n;
    return f;
  endfunction

  // Arithmetic result flags from an adder outcome
  function automatic caje_sreg_s arith_flags(input caje_sreg_s old, input caje_sum_s s,
                                             input logic word);
    caje_sreg_s f;
    f   = old;
    f.z = word ? (s.res == 16'h0000) : (s.res[DW-1:0] == 8'h00);
    f.n = word ? s.res[WW-1] : s.res[DW-1];
    f.v = s.v;
    f.s = f.n ^ s.v;
    f.c = s.c;
    f.h = word ? old.h : s.h;
    return f;
  endfunction

  // Masks of which flags each family writes
  localparam caje_sreg_s WE_FULL  = 8'h3f;  // H S V N Z C
  localparam caje_sreg_s WE_WORD  = 8'h1f;  // S V N Z C
  localparam caje_sreg_s WE_LOGIC = 8'h1e;  // S V N Z
  localparam caje_sreg_s WE_MULT  = 8'h03;  // Z C

  // ==========================================================================
  // Multiplier
  // ==========================================================================
  // Operand signedness per variant; mixed forms take the left one signed
  always_comb begin
    mul_a_s  = (I_REQ.op == OP_MULT_SIGNED) || (I_REQ.op == OP_MULT_SIGNED_UNS) ||
               (I_REQ.op == OP_FRAC_MULT_SIGNED) || (I_REQ.op == OP_FRAC_MULT_MIXED);
    mul_b_s  = (I_REQ.op == OP_MULT_SIGNED) || (I_REQ.op == OP_FRAC_MULT_SIGNED);
    mul_frac = (I_REQ.op == OP_FRAC_MULT_UNS) || (I_REQ.op == OP_FRAC_MULT_SIGNED) ||
               (I_REQ.op == OP_FRAC_MULT_MIXED);
  end

  caje_mult caje_mult_i (
    .i_a        (I_REQ.rd),
    .i_b        (I_REQ.opnd),
    .i_a_signed (mul_a_s),
    .i_b_signed (mul_b_s),
    .i_frac     (mul_frac),
    .o_prod     (mul_prod),
    .o_carry    (mul_c)
  );

  // ==========================================================================
  // Instruction evaluation
  // ==========================================================================
  // Whole outcome is formed at the start edge and latched, so the operand
  // inputs need only be valid with the start strobe
  always_comb begin
    caje_sum_s     sum;
    logic [DW-1:0] lr;
    logic [DW-1:0] bitm;
    sum           = '0;
    lr            = 8'h00;
    bitm          = 8'h01 << I_REQ.io_bit;
    calc          = '0;
    calc.dst_lo   = I_REQ.rd_idx;
    calc.dst_hi   = I_REQ.rd_idx + PAIR_STEP;
    calc.sreg     = I_REQ.sreg;
    calc.pc       = I_REQ.pc;
    calc.io_addr  = I_REQ.io_addr;
    cyc           = CYC_ALU;
    case (I_REQ.op)
      // Byte add, carry variant folds in the old carry
      OP_ADD_REG, OP_ADD_REG_CARRY: begin
        sum          = arith8(I_REQ.rd, I_REQ.opnd,
                              (I_REQ.op == OP_ADD_REG_CARRY) & I_REQ.sreg.c, 1'h0);
        calc.res_lo  = sum.res[DW-1:0];
        calc.wr_lo   = 1'h1;
        calc.sreg    = arith_flags(I_REQ.sreg, sum, 1'h0);
        calc.sreg_we = WE_FULL;
      end
      // Plain subtract, register or constant
      OP_SUB_REG, OP_SUB_IMM: begin
        sum          = arith8(I_REQ.rd, I_REQ.opnd, 1'h0, 1'h1);
        calc.res_lo  = sum.res[DW-1:0];
        calc.wr_lo   = 1'h1;
        calc.sreg    = arith_flags(I_REQ.sreg, sum, 1'h0);
        calc.sreg_we = WE_FULL;
      end
      // Subtract with borrow, register or constant
      OP_SUB_REG_BORROW, OP_SUB_IMM_BORROW: begin
        sum          = arith8(I_REQ.rd, I_REQ.opnd, I_REQ.sreg.c, 1'h1);
        calc.res_lo  = sum.res[DW-1:0];
        calc.wr_lo   = 1'h1;
        calc.sreg    = arith_flags(I_REQ.sreg, sum, 1'h0);
        calc.sreg_we = WE_FULL;
      end
      // Word add or subtract of a constant on a register pair
      OP_ADD_WORD_IMM, OP_SUB_WORD_IMM: begin
        sum          = arith16({I_REQ.rdh, I_REQ.rd}, I_REQ.opnd,
                               I_REQ.op == OP_SUB_WORD_IMM);
        calc.res_lo  = sum.res[DW-1:0];
        calc.res_hi  = sum.res[WW-1:DW];
        calc.wr_lo   = 1'h1;
        calc.wr_hi   = 1'h1;
        calc.sreg    = arith_flags(I_REQ.sreg, sum, 1'h1);
        calc.sreg_we = WE_WORD;
        cyc          = CYC_WORD;
      end
      // Bitwise logic; carry and half carry untouched
      OP_AND_REG, OP_AND_IMM, OP_OR_REG, OP_OR_IMM, OP_XOR_REG,
      OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS, OP_TEST_VALUE: begin
        case (I_REQ.op)
          OP_AND_REG, OP_AND_IMM: lr = I_REQ.rd & I_REQ.opnd;
          OP_OR_REG, OP_OR_IMM:   lr = I_REQ.rd | I_REQ.opnd;
          OP_XOR_REG:             lr = I_REQ.rd ^ I_REQ.opnd;
          OP_SET_MASK_BITS:       lr = I_REQ.rd | I_REQ.opnd;
          OP_CLEAR_MASK_BITS:     lr = I_REQ.rd & ~I_REQ.opnd;
          default:                lr = I_REQ.rd;
        endcase
        calc.res_lo  = lr;
        calc.wr_lo   = (I_REQ.op != OP_TEST_VALUE);
        calc.sreg    = logic_flags(I_REQ.sreg, lr);
        calc.sreg_we = WE_LOGIC;
      end
      // Multiplies always land in the fixed pair
      OP_MULT_UNSIGNED, OP_MULT_SIGNED, OP_MULT_SIGNED_UNS,
      OP_FRAC_MULT_UNS, OP_FRAC_MULT_SIGNED, OP_FRAC_MULT_MIXED: begin
        calc.res_lo  = mul_prod[DW-1:0];
        calc.res_hi  = mul_prod[WW-1:DW];
        calc.dst_lo  = MUL_LO_IDX;
        calc.dst_hi  = MUL_HI_IDX;
        calc.wr_lo   = 1'h1;
        calc.wr_hi   = 1'h1;
        calc.sreg.z  = (mul_prod == 16'h0000);
        calc.sreg.c  = mul_c;
        calc.sreg_we = WE_MULT;
        cyc          = CYC_MULT;
      end
      // Jumps change no flags
      OP_REL_JUMP: begin
        calc.pc    = I_REQ.pc + I_REQ.k + PC_STEP;
        calc.pc_we = 1'h1;
        cyc        = CYC_REL_JUMP;
      end
      OP_PTR_JUMP: begin
        calc.pc    = I_REQ.zptr;
        calc.pc_we = 1'h1;
        cyc        = CYC_PTR_JUMP;
      end
      OP_ABS_JUMP: begin
        calc.pc    = I_REQ.k;
        calc.pc_we = 1'h1;
        cyc        = CYC_AJMP;
      end
      // Bit set or clear writes back the whole register as read, so any
      // write-one-to-clear flag that reads as one gets cleared as well;
      // software must not rely on these to leave such flags alone
      OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
        calc.io_wdata = (I_REQ.op == OP_IO_BIT_SET) ? (I_REQ.io_val | bitm)
                                                   : (I_REQ.io_val & ~bitm);
        calc.refused  = (I_REQ.io_addr > IO_BIT_MAX);
        calc.io_we    = ~calc.refused;
        cyc           = calc.refused ? CYC_ALU : CYC_IO;
      end
      // Unknown codes complete at once with no effect
      default: begin
        calc.sreg_we = '0;
      end
    endcase
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // A start while busy is ignored; the decoder must wait for done
  always_comb begin
    regs_nxt      = regs_r;
    regs_nxt.done = 1'h0;
    case (regs_r.state)
      ST_IDLE: begin
        if (I_START) begin
          regs_nxt.res = calc;
          if (cyc == CNT_LAST) begin
            regs_nxt.done = 1'h1;
          end else begin
            regs_nxt.cnt   = cyc - CNT_LAST;
            regs_nxt.state = ST_BUSY;
          end
        end
      end
      ST_BUSY: begin
        if (regs_r.cnt == CNT_LAST) begin
          regs_nxt.done  = 1'h1;
          regs_nxt.state = ST_IDLE;
        end else begin
          regs_nxt.cnt = regs_r.cnt - CNT_LAST;
        end
      end
      // Recover from an illegal state code
      default: begin
        regs_nxt.state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      regs_r       <= '0;
      regs_r.state <= ST_IDLE;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Write enables in the result are qualified by the done pulse so a held
  // result is never committed twice
  always_comb begin
    O_BUSY            = (regs_r.state == ST_BUSY);
    O_DONE            = regs_r.done;
    O_RES             = regs_r.res;
    O_RES.wr_lo       = regs_r.res.wr_lo & regs_r.done;
    O_RES.wr_hi       = regs_r.res.wr_hi & regs_r.done;
    O_RES.pc_we       = regs_r.res.pc_we & regs_r.done;
    O_RES.io_we       = regs_r.res.io_we & regs_r.done;
    O_RES.sreg_we     = regs_r.done ? regs_r.res.sreg_we : '0;
    O_RES.refused     = regs_r.res.refused & regs_r.done;
  end

endmodule

// ===== caje_core_properties.sv
// Concurrent checks on the ports of the execution datapath.
// Assumes one core clock and the synchronous active-high core reset.
`timescale 1ns/1ns
module caje_core_properties
  import caje_pkg::*;
(
  input wire logic                I_CLK,   // Core clock
  input wire logic                I_RST,   // Core reset
  input wire logic                I_START, // Start strobe
  input wire caje_pkg::caje_req_s I_REQ,   // Instruction
  input wire logic                O_BUSY,  // Busy
  input wire logic                O_DONE,  // Done pulse
  input wire caje_pkg::caje_res_s O_RES    // Result
);
  // ==========================================================================
  // Helpers and properties
  // ==========================================================================
  // A request is only taken while idle and out of reset
  wire logic take = I_START && !O_BUSY && !I_RST;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  AST_ADD_ONE: assert property (take && I_REQ.op == OP_ADD_REG |=> O_DONE && O_RES.wr_lo && O_RES.sreg_we == 8'h3f)
    else $error("add not done in one cycle");
  AST_WORD_TWO: assert property (take && I_REQ.op == OP_ADD_WORD_IMM |=> O_BUSY && !O_DONE ##1 O_DONE && O_RES.wr_hi && O_RES.sreg_we == 8'h1f)
    else $error("word add not done in two cycles");
  AST_SUB_VALUE: assert property (take && I_REQ.op == OP_SUB_REG |=> O_RES.res_lo == $past(I_REQ.rd) - $past(I_REQ.opnd))
    else $error("subtract result wrong");
  AST_LOGIC_FLAGS: assert property (take && I_REQ.op inside {[OP_AND_REG:OP_CLEAR_MASK_BITS]} |=> O_DONE && O_RES.sreg_we == 8'h1e && !O_RES.sreg.v)
    else $error("logic op flag set wrong");
  AST_TEST_KEEP: assert property (take && I_REQ.op == OP_TEST_VALUE |=> O_DONE && !O_RES.wr_lo)
    else $error("test op wrote the register");
  AST_MULT_PAIR: assert property (take && I_REQ.op inside {[OP_MULT_UNSIGNED:OP_FRAC_MULT_MIXED]} |=> O_BUSY ##1 O_DONE && O_RES.dst_lo == 5'h00 && O_RES.dst_hi == 5'h01 && O_RES.sreg_we == 8'h03)
    else $error("multiply target or timing wrong");
  AST_ABS_JUMP: assert property (take && I_REQ.op == OP_ABS_JUMP |=> O_BUSY [*2] ##1 O_DONE && O_RES.pc_we && O_RES.pc == $past(I_REQ.k, 3) && O_RES.sreg_we == 8'h00)
    else $error("absolute jump wrong");
  AST_IO_RANGE: assert property (take && I_REQ.op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR} && I_REQ.io_addr > 6'h1f |=> O_DONE && O_RES.refused && !O_RES.io_we)
    else $error("bit access above range not refused");
  AST_IO_RMW: assert property (take && I_REQ.op == OP_IO_BIT_SET && I_REQ.io_addr <= 6'h1f |=> ##1 O_DONE && O_RES.io_we && O_RES.io_wdata == ($past(I_REQ.io_val, 2) | (8'h01 << $past(I_REQ.io_bit, 2))))
    else $error("bit set write-back wrong");
  AST_GATED: assert property (!O_DONE |-> !O_RES.wr_lo && !O_RES.pc_we && !O_RES.io_we)
    else $error("enable outside done pulse");
endmodule
bind caje_core caje_core_properties caje_core_properties_i (.I_CLK(I_CLK), .I_RST(I_RST), .I_START(I_START),
  .I_REQ(I_REQ), .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_RES(O_RES));

// ===== caje_core_test.sv
// Self-checking bench for the execution datapath, driving its ports directly.
// Assumes the checker is bound to the core from its own file.
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module caje_core_test;
  import caje_pkg::*;
  logic       I_CLK = 1'b0;  // Core clock
  logic       I_RST = 1'b1;  // Core reset
  logic       I_START = 1'b0; // Start strobe
  caje_req_s  I_REQ = '0;    // Request presented
  caje_req_s  rq;            // Request being built
  logic       O_BUSY;        // Busy
  logic       O_DONE;        // Done pulse
  caje_res_s  O_RES;         // Result
  int         bad_count = 0;       // Mismatches
  int         samples_checked = 0; // Comparisons
  caje_op_e   mo [6] = '{OP_MULT_UNSIGNED, OP_MULT_SIGNED, OP_MULT_SIGNED_UNS, OP_FRAC_MULT_UNS,
                         OP_FRAC_MULT_SIGNED, OP_FRAC_MULT_MIXED};
  logic [7:0]  ma [6] = '{8'hff, 8'hff, 8'hff, 8'h80, 8'h80, 8'hc0}; // Left operands
  logic [7:0]  mb [6] = '{8'hff, 8'hff, 8'h02, 8'h80, 8'h80, 8'h80}; // Right operands
  logic [15:0] mp [6] = '{16'hfe01, 16'h0001, 16'hfffe, 16'h8000, 16'h8000, 16'hc000}; // Products
  logic        mc [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1}; // Carry out
  caje_core caje_core_i (.I_CLK(I_CLK), .I_RST(I_RST), .I_START(I_START), .I_REQ(I_REQ),
    .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_RES(O_RES));
  // ==========================================================================
  // Clock, watchdog and verdict
  // ==========================================================================
  // 50 MHz clock
  initial begin
    forever #10 I_CLK = ~I_CLK;
  end
  // All tests need well under a thousand cycles
  initial begin
    #40000;
    bad_count++;
    results();
  end
  // Prints counts and the verdict, then stops
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================================
  // Access tasks
  // ==========================================================================
  // Starts a clean request with destination register 4
  task automatic set(input caje_op_e op, input logic [7:0] rd, input logic [7:0] opnd);
    rq = '0;
    rq.op = op;
    rq.rd = rd;
    rq.opnd = opnd;
    rq.rd_idx = 5'h04;
  endtask
  // Issues rq and counts the cycles until the done pulse
  task automatic go(input int n);
    int c;
    I_REQ = rq;
    I_START = 1'b1;
    @(posedge I_CLK);
    #1 I_START = 1'b0;
    c = 1;
    while (O_DONE !== 1'b1 && c < 9) begin
      @(posedge I_CLK);
      #1 c++;
    end
    `CHK("cycles", n, c)
  endtask
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    repeat (10) @(posedge I_CLK);
    #1 I_RST = 1'b0;
    `CHK("reset result", '0, O_RES)
    set(OP_ADD_REG, 8'h7f, 8'h01); go(1);
    `CHK("add", {8'h80, 6'h2c}, {O_RES.res_lo, O_RES.sreg[5:0]})
    set(OP_ADD_REG_CARRY, 8'hff, 8'h00); rq.sreg.c = 1'b1; go(1);
    `CHK("add carry", {8'h00, 6'h23}, {O_RES.res_lo, O_RES.sreg[5:0]})
    set(OP_SUB_IMM, 8'h10, 8'h01); go(1);
    `CHK("sub", {8'h0f, 6'h20}, {O_RES.res_lo, O_RES.sreg[5:0]})
    set(OP_SUB_REG_BORROW, 8'h00, 8'h00); rq.sreg.c = 1'b1; go(1);
    `CHK("sub borrow", {8'hff, 6'h35}, {O_RES.res_lo, O_RES.sreg[5:0]})
    set(OP_SUB_REG, 8'h80, 8'h01); go(1); `CHK("sub reg", {8'h7f, 6'h38}, {O_RES.res_lo, O_RES.sreg[5:0]})
    set(OP_SUB_IMM_BORROW, 8'h10, 8'h0f); rq.sreg.c = 1'b1; go(1);
    `CHK("sub imm borrow", {8'h00, 6'h22}, {O_RES.res_lo, O_RES.sreg[5:0]})
    $display("test byte arithmetic done");
    set(OP_ADD_WORD_IMM, 8'hff, 8'h01); go(2);
    `CHK("word add", {16'h0100, 5'h05, 5'h00}, {O_RES.res_hi, O_RES.res_lo, O_RES.dst_hi, O_RES.sreg[4:0]})
    set(OP_SUB_WORD_IMM, 8'h00, 8'h01); go(2);
    `CHK("word sub", {16'hffff, 5'h15}, {O_RES.res_hi, O_RES.res_lo, O_RES.sreg[4:0]})
    $display("test word arithmetic done");
    set(OP_AND_IMM, 8'hc3, 8'h5a); go(1); `CHK("and", 8'h42, O_RES.res_lo)
    set(OP_OR_REG, 8'hc3, 8'h5a); go(1); `CHK("or", 8'hdb, O_RES.res_lo)
    set(OP_XOR_REG, 8'hc3, 8'h5a); go(1); `CHK("xor", 8'h99, O_RES.res_lo)
    set(OP_SET_MASK_BITS, 8'h01, 8'h80); go(1); `CHK("set mask", 8'h81, O_RES.res_lo)
    set(OP_CLEAR_MASK_BITS, 8'hff, 8'h0f); go(1); `CHK("clear mask", 8'hf0, O_RES.res_lo)
    set(OP_TEST_VALUE, 8'h00, 8'h00); go(1); `CHK("test flags", 2'b01, O_RES.sreg[2:1])
    set(OP_AND_REG, 8'h0f, 8'hf0); go(1); `CHK("and reg", {8'h00, 2'b01}, {O_RES.res_lo, O_RES.sreg[2:1]})
    set(OP_OR_IMM, 8'h80, 8'h01); go(1); `CHK("or imm", {8'h81, 2'b10}, {O_RES.res_lo, O_RES.sreg[2:1]})
    $display("test logic done");
    for (int i = 0; i < 6; i++) begin
      set(mo[i], ma[i], mb[i]); go(2);
      `CHK("product", {mp[i], 1'b0, mc[i]}, {O_RES.res_hi, O_RES.res_lo, O_RES.sreg.z, O_RES.sreg.c})
    end
    set(OP_MULT_SIGNED, 8'h00, 8'h7f); go(2); `CHK("zero product", 2'b10, {O_RES.sreg.z, O_RES.sreg.c})
    $display("test multiply done");
    set(OP_REL_JUMP, 8'h00, 8'h00); rq.pc = 16'h0100; rq.k = 16'hfffe; go(2);
    `CHK("rel jump", 16'h00ff, O_RES.pc)
    set(OP_PTR_JUMP, 8'h00, 8'h00); rq.zptr = 16'h1234; go(2); `CHK("ptr jump", 16'h1234, O_RES.pc)
    set(OP_ABS_JUMP, 8'h00, 8'h00); rq.k = 16'h2000; go(3); `CHK("abs jump", 16'h2000, O_RES.pc)
    $display("test jumps done");
    set(OP_IO_BIT_SET, 8'h00, 8'h00); rq.io_addr = 6'h1f; rq.io_val = 8'h81; rq.io_bit = 3'h2; go(2);
    `CHK("bit set", {6'h1f, 8'h85}, {O_RES.io_addr, O_RES.io_wdata})
    rq.op = OP_IO_BIT_CLEAR; rq.io_bit = 3'h0; go(2); `CHK("bit clear", 8'h80, O_RES.io_wdata)
    rq.io_addr = 6'h20; go(1); `CHK("refused", 2'b10, {O_RES.refused, O_RES.io_we})
    $display("test io bits done");
    results();
  end
endmodule

// ===== caje_mult.sv
// 8x8 multiplier with signed, unsigned and mixed operands and fractional shift.
// Purely combinational; the caller registers the product.
`timescale 1ns/1ns
module caje_mult
  import caje_pkg::*;
(
  input  wire logic [caje_pkg::DW-1:0] i_a,        // Left operand
  input  wire logic [caje_pkg::DW-1:0] i_b,        // Right operand
  input  wire logic                    i_a_signed, // Left operand is signed
  input  wire logic                    i_b_signed, // Right operand is signed
  input  wire logic                    i_frac,     // Shift product left by one
  output logic      [caje_pkg::WW-1:0] o_prod,     // Stored product
  output logic                         o_carry     // Top bit before the shift
);

  // ==========================================================================
  // Product
  // ==========================================================================
  logic signed [DW:0]     a_ext;  // Operand widened by sign or zero
  logic signed [DW:0]     b_ext;
  logic signed [2*DW+1:0] full;   // Exact product
  logic        [WW-1:0]   raw;    // Product before the fractional shift

  // Widening by one bit lets one signed multiplier serve all three modes
  always_comb begin
    a_ext   = $signed({i_a_signed & i_a[DW-1], i_a});
    b_ext   = $signed({i_b_signed & i_b[DW-1], i_b});
    full    = a_ext * b_ext;
    raw     = full[WW-1:0];
    o_carry = raw[WW-1];
    o_prod  = i_frac ? {raw[WW-2:0], 1'h0} : raw;
  end

endmodule

// ===== caje_pkg.sv
// Shared types and constants for the execution datapath of the 8-bit core.
// Assumes a single core clock and a synchronous, active-high core reset.
package caje_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned DW     = 8;   // Data register width
  localparam int unsigned WW     = 16;  // Register pair and program counter width
  localparam int unsigned RIDX_W = 5;   // Register file index width
  localparam int unsigned IOA_W  = 6;   // I/O space address width
  localparam int unsigned CNT_W  = 2;   // Cycle counter width

  // ==========================================================================
  // Cycle counts
  // ==========================================================================
  localparam logic [CNT_W-1:0] CYC_ALU  = 2'h1;  // Byte arithmetic and logic
  localparam logic [CNT_W-1:0] CYC_WORD = 2'h2;  // Word add and subtract
  localparam logic [CNT_W-1:0] CYC_MULT = 2'h2;  // All multiplies
  localparam logic [CNT_W-1:0] CYC_REL_JUMP = 2'h2;  // Relative jump
  localparam logic [CNT_W-1:0] CYC_PTR_JUMP = 2'h2;  // Jump through the Z pointer
  localparam logic [CNT_W-1:0] CYC_AJMP = 2'h3;  // Absolute jump
  localparam logic [CNT_W-1:0] CYC_IO   = 2'h2;  // Single-bit I/O set and clear
  localparam logic [CNT_W-1:0] CNT_LAST = 2'h1;  // Counter value of the final cycle

  // ==========================================================================
  // Fixed addresses and limits
  // ==========================================================================
  localparam logic [RIDX_W-1:0] MUL_LO_IDX = 5'h00;  // Product low byte register
  localparam logic [RIDX_W-1:0] MUL_HI_IDX = 5'h01;  // Product high byte register
  localparam logic [RIDX_W-1:0] PAIR_STEP  = 5'h01;  // High register follows low
  localparam logic [IOA_W-1:0]  IO_BIT_MAX = 6'h1f;  // Top of bit-addressable I/O
  localparam logic [WW-1:0]     PC_STEP    = 16'h0001;

  // ==========================================================================
  // Operations
  // ==========================================================================
  typedef enum logic [4:0] {
    OP_ADD_REG          = 5'h00,
    OP_ADD_REG_CARRY    = 5'h01,
    OP_ADD_WORD_IMM     = 5'h02,
    OP_SUB_REG          = 5'h03,
    OP_SUB_IMM          = 5'h04,
    OP_SUB_REG_BORROW   = 5'h05,
    OP_SUB_IMM_BORROW   = 5'h06,
    OP_SUB_WORD_IMM     = 5'h07,
    OP_AND_REG          = 5'h08,
    OP_AND_IMM          = 5'h09,
    OP_OR_REG           = 5'h0a,
    OP_OR_IMM           = 5'h0b,
    OP_XOR_REG          = 5'h0c,
    OP_SET_MASK_BITS    = 5'h0d,
    OP_CLEAR_MASK_BITS  = 5'h0e,
    OP_TEST_VALUE       = 5'h0f,
    OP_MULT_UNSIGNED    = 5'h10,
    OP_MULT_SIGNED      = 5'h11,
    OP_MULT_SIGNED_UNS  = 5'h12,
    OP_FRAC_MULT_UNS    = 5'h13,
    OP_FRAC_MULT_SIGNED = 5'h14,
    OP_FRAC_MULT_MIXED  = 5'h15,
    OP_REL_JUMP         = 5'h16,
    OP_PTR_JUMP         = 5'h17,
    OP_ABS_JUMP         = 5'h18,
    OP_IO_BIT_SET       = 5'h19,
    OP_IO_BIT_CLEAR     = 5'h1a
  } caje_op_e;

  // Controller states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_BUSY = 2'h2
  } caje_state_e;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  // Status flags, top bit first
  typedef struct packed {
    logic i;  // Global interrupt enable
    logic t;  // Bit copy storage
    logic h;  // Half carry
    logic s;  // Sign, negative xor overflow
    logic v;  // Two's complement overflow
    logic n;  // Negative
    logic z;  // Zero
    logic c;  // Carry
  } caje_sreg_s;

  // One instruction handed to the unit
  typedef struct packed {
    caje_op_e          op;      // Operation
    logic [RIDX_W-1:0] rd_idx;  // Destination (low register for word ops)
    logic [DW-1:0]     rd;      // Destination value
    logic [DW-1:0]     rdh;     // High register value for word ops
    logic [DW-1:0]     opnd;    // Second register or constant
    logic [WW-1:0]     k;       // Jump offset or absolute target
    logic [WW-1:0]     pc;      // Address of the current instruction
    logic [WW-1:0]     zptr;    // Z pointer
    logic [IOA_W-1:0]  io_addr; // I/O register address
    logic [2:0]        io_bit;  // Bit number within the I/O register
    logic [DW-1:0]     io_val;  // Present I/O register contents
    caje_sreg_s        sreg;    // Present status flags
  } caje_req_s;

  // Outcome of one instruction
  typedef struct packed {
    logic [DW-1:0]     res_lo;   // Low or only result byte
    logic [DW-1:0]     res_hi;   // High result byte
    logic [RIDX_W-1:0] dst_lo;   // Register for res_lo
    logic [RIDX_W-1:0] dst_hi;   // Register for res_hi
    logic              wr_lo;    // Write res_lo
    logic              wr_hi;    // Write res_hi
    caje_sreg_s        sreg;     // New flags
    caje_sreg_s        sreg_we;  // Flags that are updated
    logic [WW-1:0]     pc;       // New program counter
    logic              pc_we;    // Load the program counter
    logic [IOA_W-1:0]  io_addr;  // I/O write address
    logic [DW-1:0]     io_wdata; // Whole-register write-back
    logic              io_we;    // I/O write
    logic              refused;  // Bit access outside the bit range
  } caje_res_s;

  // Adder outcome
  typedef struct packed {
    logic [WW-1:0] res;
    logic          c;
    logic          h;
    logic          v;
  } caje_sum_s;

endpackage
